// [src/analog_input_scaling.sv]
/*
  Analog input scaling: raw converter count plus offset, times multiplier,
  divided by divisor, per channel, with object dictionary access.
  Assumes the dictionary request arrives synchronous to I_CLK, one per
  cycle at most, and raw counts are sampled synchronous to I_CLK.
*/
// Operation
// - subentry zero of each array reads channel count, preset to two
// - each channel result is a read-only signed 32-bit value
// - with default offset and factors the result equals the raw count
// - voltage input: count times 3.3 V over 1023 gives the voltage
// - current input: count times 20 mA over 1023 gives the current
// - offset is added to the raw count before scaling
// - each channel has a read-write signed 16-bit offset, reset zero
// - offset-corrected value is multiplied by the channel multiplier
// - each channel has a read-write signed 16-bit multiplier, reset one
// - the offset-corrected product is divided by the channel divisor
// - each channel has a read-write signed 16-bit divisor, reset one
// - second channel entries exist only when the second input exists
// - offset and factors are savable settings, results are not
// - divisor subentries one and two belong to inputs one and two
`timescale 1ns/100ps

module analog_input_scaling
  import ain_scale_pkg::*;
#(
  parameter int NUM_CH = 2               // analog inputs present, 1 or 2
)
(
  input  wire logic                 I_CLK,        // system clock 125 MHz
  input  wire logic                 I_RST_B,      // sync reset, active low
  input  wire logic [NUM_CH*RAW_W-1:0] I_RAW,     // raw counts, ch1 low
  input  wire od_req_t              I_REQ,        // dictionary access
  output      od_rsp_t              O_RSP,        // answer, one cycle later
  output      logic [NUM_CH*32-1:0] O_RESULT,     // scaled results, ch1 low
  output      logic [NUM_CH*48-1:0] O_SAVE        // savable settings image
);

  // =========================================================
  // parameter check
  if (NUM_CH < 1 || NUM_CH > 2)
  begin : g_bad
    $error("NUM_CH must be 1 or 2");
  end

  // =========================================================
  // helpers
  // voltage in mV and current in uA from a raw count
  function automatic logic [31:0] to_mv(input logic [RAW_W-1:0] c);
    to_mv = 32'((int'(c) * FULL_SCALE_MV) / FULL_SCALE_DIGITS);
  endfunction

  function automatic logic [31:0] to_ua(input logic [RAW_W-1:0] c);
    to_ua = 32'((int'(c) * FULL_SCALE_UA) / FULL_SCALE_DIGITS);
  endfunction

  // subentry to channel number, or NUM_CH when not mapped
  function automatic int chan_of(input logic [7:0] s);
    chan_of = (s == SUB_CH1) ? 0 :
              ((s == SUB_CH2 && NUM_CH > 1) ? 1 : NUM_CH);
  endfunction

  // =========================================================
  // settings
  chan_cfg_t cfg_q [NUM_CH];
  chan_cfg_t cfg_d [NUM_CH];
  od_rsp_t   rsp_q;
  od_rsp_t   rsp_d;
  int        ch;

  // dictionary decode and settings update
  always_comb
  begin
    ch    = chan_of(I_REQ.sub);
    rsp_d = '0;
    for (int i = 0; i < NUM_CH; i++)
      cfg_d[i] = cfg_q[i];
    rsp_d.ack = I_REQ.rd | I_REQ.wr;
    if (I_REQ.rd)
    begin
      if (I_REQ.sub == SUB_COUNT && (I_REQ.index == IDX_RESULT ||
          I_REQ.index == IDX_OFFSET || I_REQ.index == IDX_MULT ||
          I_REQ.index == IDX_DIV))
        rsp_d.rdata = {24'h00_0000, CHAN_COUNT};
      else if (ch < NUM_CH)
      begin
        unique case (I_REQ.index)
          IDX_RESULT: rsp_d.rdata = O_RESULT[ch*32 +: 32];
          IDX_OFFSET: rsp_d.rdata = 32'(cfg_q[ch].offset);
          IDX_MULT:   rsp_d.rdata = 32'(cfg_q[ch].mult);
          IDX_DIV:    rsp_d.rdata = 32'(cfg_q[ch].div);
          default:    rsp_d.err   = 1'b1;
        endcase
      end
      else
        rsp_d.err = 1'b1;
    end
    else if (I_REQ.wr)
    begin
      // results and counts are read-only; writes there are refused
      if (ch < NUM_CH && I_REQ.index == IDX_OFFSET)
        cfg_d[ch].offset = I_REQ.wdata[15:0];
      else if (ch < NUM_CH && I_REQ.index == IDX_MULT)
        cfg_d[ch].mult = I_REQ.wdata[15:0];
      else if (ch < NUM_CH && I_REQ.index == IDX_DIV)
        cfg_d[ch].div = I_REQ.wdata[15:0];
      else
        rsp_d.err = 1'b1;
    end
  end

  // register settings and answer
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      for (int i = 0; i < NUM_CH; i++)
        cfg_q[i] <= '{OFFSET_RST, MULT_RST, DIV_RST};
      rsp_q <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
        cfg_q[i] <= cfg_d[i];
      rsp_q <= rsp_d;
    end
  end

  assign O_RSP = rsp_q;

  // =========================================================
  // datapath, one result register per channel
  logic [NUM_CH*32-1:0] res_q;
  logic [NUM_CH*32-1:0] res_d;
  logic [NUM_CH*48-1:0] save_q;
  logic [NUM_CH*48-1:0] save_d;

  // offset, multiply, divide; product kept 48 bits so nothing wraps
  always_comb
  begin
    logic signed [SUM_W-1:0]  sum;
    logic signed [PROD_W-1:0] prod;
    logic signed [PROD_W-1:0] quo;
    sum    = '0;
    prod   = '0;
    quo    = '0;
    res_d  = res_q;
    save_d = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      sum  = SUM_W'($signed({1'b0, I_RAW[i*RAW_W +: RAW_W]}))
           + SUM_W'(cfg_q[i].offset);
      prod = PROD_W'(sum) * PROD_W'(cfg_q[i].mult);
      if (cfg_q[i].div != 16'sh0000)
      begin
        quo = prod / PROD_W'(cfg_q[i].div);
        res_d[i*32 +: 32] = quo[31:0];
      end
      // only settings enter the save image, never the result
      save_d[i*48 +: 48] = cfg_q[i];
    end
  end

  // register results
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      res_q  <= '0;
      save_q <= '0;
    end
    else
    begin
      res_q  <= res_d;
      save_q <= save_d;
    end
  end

  assign O_RESULT = res_q;
  assign O_SAVE   = save_q;

  // =========================================================
  // checks
  logic [RAW_W-1:0] raw0;
  assign raw0 = I_RAW[RAW_W-1:0];

  sequence s_default_cfg;
    cfg_q[0] == chan_cfg_t'{OFFSET_RST, MULT_RST, DIV_RST};
  endsequence

  property p_identity;
    @(posedge I_CLK) disable iff (!I_RST_B)
    s_default_cfg |=> (O_RESULT[31:0] == 32'($past(raw0)));
  endproperty

  AST_IDENTITY: assert property (p_identity)
    else $error("default settings do not pass raw count");

  AST_ZERO_DIV: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    (cfg_q[0].div == 16'sh0000) |=> $stable(O_RESULT[31:0]))
    else $error("zero divisor changed the result");

  AST_COUNT_RD: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    (I_REQ.rd && I_REQ.sub == SUB_COUNT && I_REQ.index == IDX_DIV)
      |=> (O_RSP.ack && O_RSP.rdata == 32'(CHAN_COUNT)))
    else $error("channel count read wrong");

  AST_RES_RO: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    (I_REQ.wr && I_REQ.index == IDX_RESULT) |=> O_RSP.err)
    else $error("result write not refused");

  AST_OFS_WR: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    (I_REQ.wr && I_REQ.index == IDX_OFFSET && I_REQ.sub == SUB_CH1)
      |=> (cfg_q[0].offset == $past(I_REQ.wdata[15:0])))
    else $error("offset write lost");

  AST_MUL_WR: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    (I_REQ.wr && I_REQ.index == IDX_MULT && I_REQ.sub == SUB_CH1)
      |=> (cfg_q[0].mult == $past(I_REQ.wdata[15:0])))
    else $error("multiplier write lost");

  AST_DIV_WR: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    (I_REQ.wr && I_REQ.index == IDX_DIV && I_REQ.sub == SUB_CH1)
      |=> (cfg_q[0].div == $past(I_REQ.wdata[15:0])))
    else $error("divisor write lost");

  AST_RESET: assert property (
    @(posedge I_CLK)
    !I_RST_B |=> (cfg_q[0].div == DIV_RST && cfg_q[0].mult == MULT_RST
                  && O_RESULT[31:0] == RESULT_RST))
    else $error("reset presets wrong");

  // unit scaling on input one, checked against the millivolt helper
  AST_VOLT: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    (cfg_q[0] == chan_cfg_t'{OFFSET_RST, 16'(FULL_SCALE_MV),
                             16'(FULL_SCALE_DIGITS)})
      |=> (O_RESULT[31:0] == to_mv($past(raw0))))
    else $error("voltage scaling wrong");

  // current scaling on the second input, only when it is built
  if (NUM_CH > 1)
  begin : g_curr_chk
    AST_CURR: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      (cfg_q[1] == chan_cfg_t'{OFFSET_RST, 16'(FULL_SCALE_UA),
                               16'(FULL_SCALE_DIGITS)})
        |=> (O_RESULT[32 +: 32] == to_ua($past(I_RAW[RAW_W +: RAW_W]))))
      else $error("current scaling wrong");
  end

endmodule

// [src/ain_scale_pkg.sv]
/*
  Package for the analog input scaling block: object dictionary indices,
  subentry numbers, preset values and datapath widths.
  Assumes a single 125 MHz system clock and a synchronous active-low reset.
*/
package ain_scale_pkg;

  // object indices of the four arrays
  localparam logic [15:0] IDX_RESULT  = 16'h3320;
  localparam logic [15:0] IDX_OFFSET  = 16'h3321;
  localparam logic [15:0] IDX_MULT    = 16'h3322;
  localparam logic [15:0] IDX_DIV     = 16'h3323;

  // subentries
  localparam logic [7:0]  SUB_COUNT   = 8'h00;
  localparam logic [7:0]  SUB_CH1     = 8'h01;
  localparam logic [7:0]  SUB_CH2     = 8'h02;

  // presets
  localparam logic [7:0]  CHAN_COUNT  = 8'h02;
  localparam logic [15:0] OFFSET_RST  = 16'h0000;
  localparam logic [15:0] MULT_RST    = 16'h0001;
  localparam logic [15:0] DIV_RST     = 16'h0001;
  localparam logic [31:0] RESULT_RST  = 32'h0000_0000;

  // converter full scale in digits, voltage in mV, current in uA
  localparam int          FULL_SCALE_DIGITS = 1023;
  localparam int          FULL_SCALE_MV     = 3300;
  localparam int          FULL_SCALE_UA     = 20000;

  // widths
  localparam int          RAW_W   = 10;
  localparam int          SUM_W   = 18;
  localparam int          PROD_W  = 48;

  // one dictionary access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } od_req_t;

  // one answer to an access
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } od_rsp_t;

  // per-channel settings
  typedef struct packed {
    logic signed [15:0] offset;
    logic signed [15:0] mult;
    logic signed [15:0] div;
  } chan_cfg_t;

endpackage

// [tb/od_master.sv]
/*
  Fieldbus master model: issues one dictionary access at a time.
  Assumes the block takes a request on the rising edge and answers
  on that same edge, ready by the next falling one.
*/
`timescale 1ns/100ps
module od_master
  import ain_scale_pkg::*;
(
  input  wire logic    i_clk, // system clock
  output      od_req_t o_req, // access to the block
  input  wire od_rsp_t i_rsp  // answer from the block
);
  // ==========================================================
  // access task
  // released index, sub and data show inverted garbage, never the old value; rd and wr drop to zero
  initial o_req = '0;

  task automatic access(input logic w, input logic [15:0] ix,
    input logic [7:0] sb, input logic [31:0] wd,
    output logic [31:0] rd, output logic er, output logic ok);
    begin
      @(negedge i_clk);
      o_req = '{rd: !w, wr: w, index: ix, sub: sb, wdata: wd};
      // answer stands for one cycle after the taking edge
      @(negedge i_clk);
      ok = i_rsp.ack;
      er = i_rsp.err;
      rd = i_rsp.rdata;
      o_req = '{rd: 1'b0, wr: 1'b0, index: ~ix, sub: ~sb, wdata: ~wd};
    end
  endtask
endmodule

// [tb/testbench.sv]
/*
  Self-checking bench for the analog input scaling block.
  Assumes the fieldbus master model and the package are compiled first.
*/
`timescale 1ns/100ps
module testbench
  import ain_scale_pkg::*;
;
  logic        i_clk;
  logic        i_rst_b;
  logic [19:0] raw;
  od_req_t     req;
  od_rsp_t     rsp;
  logic [63:0] res;
  logic [95:0] save;
  int          bad_count;
  int          samples_checked;

  analog_input_scaling #(.NUM_CH(2)) analog_input_scaling_inst (
    .I_CLK(i_clk), .I_RST_B(i_rst_b), .I_RAW(raw), .I_REQ(req),
    .O_RSP(rsp), .O_RESULT(res), .O_SAVE(save));
  od_master od_master_inst (.i_clk(i_clk), .o_req(req), .i_rsp(rsp));

  // ==========================================================
  // helpers
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        bad_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // one access, answer and err flag judged
  task automatic acc(input int w, input logic [15:0] ix,
    input logic [7:0] sb, input logic [31:0] wd, input logic [31:0] xr,
    input int xe);
    logic [31:0] r;
    logic        e;
    logic        k;
    begin
      od_master_inst.access(1'(w), ix, sb, wd, r, e, k);
      chk({47'h0, k}, 48'h1);
      chk({47'h0, e}, {47'h0, 1'(xe)});
      if (w == 0) chk({16'h0, r}, {16'h0, xr});
    end
  endtask

  // result lands one edge after raw or settings change
  task automatic rchk(input int ch, input logic [31:0] x);
    begin
      @(negedge i_clk);
      @(negedge i_clk);
      chk({16'h0, res[ch*32+:32]}, {16'h0, x});
    end
  endtask

  // truncating division, as the block must do
  function automatic logic [31:0] scl(int r, int o, int m, int d);
    longint p;
    p = longint'(r + o) * m;
    return 32'(p / d);
  endfunction

  task automatic final_report();
    begin
      $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    begin
      for (int i = 0; i < 4; i++)
        acc(0, IDX_RESULT + 16'(i), 8'h00, 0, 32'h2, 0);
      acc(0, IDX_OFFSET, 8'h01, 0, 32'h0, 0);
      acc(0, IDX_MULT, 8'h02, 0, 32'h1, 0);
      acc(0, IDX_DIV, 8'h01, 0, 32'h1, 0);
      raw = {10'd513, 10'd1000};
      rchk(0, 32'd1000);
      acc(0, IDX_RESULT, 8'h02, 0, 32'd513, 0);
      $display("reset test done");
    end
  endtask

  task automatic t_scale();
    begin
      acc(1, IDX_OFFSET, 8'h01, 32'hfffd, 0, 0);
      acc(1, IDX_MULT, 8'h01, 32'hfff9, 0, 0);
      acc(1, IDX_DIV, 8'h01, 32'h2, 0, 0);
      acc(1, IDX_MULT, 8'h02, 32'h3, 0, 0);
      acc(1, IDX_DIV, 8'h02, 32'h4, 0, 0);
      rchk(0, scl(1000, -3, -7, 2));
      rchk(1, scl(513, 0, 3, 4));
      acc(0, IDX_OFFSET, 8'h01, 0, 32'hffff_fffd, 0);
      $display("scale test done");
    end
  endtask

  task automatic t_refuse();
    begin
      acc(1, IDX_RESULT, 8'h01, 32'h7, 0, 1);
      acc(1, IDX_MULT, 8'h00, 32'h7, 0, 1);
      acc(1, IDX_OFFSET, 8'h03, 32'h7, 0, 1);
      acc(0, 16'h3324, 8'h01, 0, 32'h0, 1);
      acc(0, IDX_MULT, 8'h01, 0, 32'hffff_fff9, 0);
      $display("refusal test done");
    end
  endtask

  task automatic t_divzero();
    begin
      acc(1, IDX_DIV, 8'h01, 32'h0, 0, 0);
      raw[9:0] = 10'd5;
      rchk(0, scl(1000, -3, -7, 2));
      chk(save[47:0], 48'hfffd_fff9_0000);
      chk(save[95:48], 48'h0000_0003_0004);
      $display("zero divisor test done");
    end
  endtask

  task automatic t_units();
    begin
      acc(1, IDX_OFFSET, 8'h01, 32'h0, 0, 0);
      acc(1, IDX_MULT, 8'h01, FULL_SCALE_MV, 0, 0);
      acc(1, IDX_DIV, 8'h01, FULL_SCALE_DIGITS, 0, 0);
      acc(1, IDX_MULT, 8'h02, FULL_SCALE_UA, 0, 0);
      acc(1, IDX_DIV, 8'h02, FULL_SCALE_DIGITS, 0, 0);
      raw = {10'd1023, 10'd1023};
      rchk(0, 32'd3300);
      rchk(1, 32'd20000);
      $display("units test done");
    end
  endtask

  // reset in mid-run must zero result one and bring offset one, multiplier one and divisor two back to their presets
  task automatic t_rerst();
    begin
      @(negedge i_clk);
      i_rst_b = 1'b0;
      repeat (2) @(negedge i_clk);
      chk({16'h0, res[31:0]}, 48'h0);
      i_rst_b = 1'b1;
      acc(0, IDX_OFFSET, 8'h01, 0, 32'h0, 0);
      acc(0, IDX_MULT, 8'h01, 0, 32'h1, 0);
      acc(0, IDX_DIV, 8'h02, 0, 32'h1, 0);
      rchk(1, 32'd1023);
      $display("mid-run reset test done");
    end
  endtask

  // ==========================================================
  // clock, reset and sequence
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  initial
  begin
    bad_count = 0;
    samples_checked = 0;
    i_rst_b = 1'b0;
    raw = 20'h0;
    repeat (3) @(negedge i_clk);
    i_rst_b = 1'b1;
    t_reset();
    t_scale();
    t_refuse();
    t_divzero();
    t_units();
    t_rerst();
    final_report();
  end
endmodule
